// ---- rtl/mpeg_defines.svh ----
// Offsets, field positions, reset values and widths for the pulse edge generator.
// Assumes inclusion by bare name from the package and the design module.
`ifndef MPEG_DEFINES_SVH
`define MPEG_DEFINES_SVH
`define MPEG_CW 16
`define MPEG_ADDR_CTRL 12'h000
`define MPEG_ADDR_PERIOD 12'h004
`define MPEG_ADDR_EV1 12'h008
`define MPEG_ADDR_EV2 12'h00c
`define MPEG_ADDR_EV3 12'h010
`define MPEG_ADDR_EV4 12'h014
`define MPEG_ADDR_CADJ_A 12'h018
`define MPEG_ADDR_CADJ_B 12'h01c
`define MPEG_ADDR_ADAPT 12'h020
`define MPEG_ADDR_PHASE 12'h024
`define MPEG_ADDR_STRIG1 12'h028
`define MPEG_ADDR_STRIG2 12'h02c
`define MPEG_ADDR_BLKA_BEG 12'h030
`define MPEG_ADDR_BLKA_END 12'h034
`define MPEG_ADDR_BLKB_BEG 12'h038
`define MPEG_ADDR_BLKB_END 12'h03c
`define MPEG_ADDR_STATUS 12'h040
`define MPEG_CTRL_EN_BIT 0
`define MPEG_CTRL_MODE_LSB 1
`define MPEG_CTRL_PHSRC_BIT 4
`define MPEG_RST_PERIOD 16'h03e7
`define MPEG_RST_ZERO 16'h0000
`endif

// ---- rtl/mpeg_pkg.sv ----
// Types for the pulse edge generator.
// Assumes the defines header is compiled alongside.
`include "mpeg_defines.svh"
package mpeg_pkg;
	typedef logic [`MPEG_CW-1:0] mpeg_cnt_t;
	typedef enum logic [2:0] {
		MPEG_NORMAL,
		MPEG_MULTI,
		MPEG_RESONANT,
		MPEG_TRIANGLE,
		MPEG_LEADING
	} mpeg_mode_t;
	typedef struct packed {
		logic en;
		logic [2:0] mode;
		logic phsrc;
		mpeg_cnt_t period;
		mpeg_cnt_t ev1;
		mpeg_cnt_t ev2;
		mpeg_cnt_t ev3;
		mpeg_cnt_t ev4;
		mpeg_cnt_t cadj_a;
		mpeg_cnt_t cadj_b;
		mpeg_cnt_t adapt;
		mpeg_cnt_t phase;
		mpeg_cnt_t st1;
		mpeg_cnt_t st2;
		mpeg_cnt_t ba_b;
		mpeg_cnt_t ba_e;
		mpeg_cnt_t bb_b;
		mpeg_cnt_t bb_e;
		mpeg_cnt_t cnt;
		logic [2:0] lmode;
		mpeg_cnt_t a_rise;
		mpeg_cnt_t a_fall;
		mpeg_cnt_t b_rise;
		mpeg_cnt_t b_fall;
		mpeg_cnt_t ast_a;
		mpeg_cnt_t ast_b;
		mpeg_cnt_t ph_pos;
		logic a_on;
		logic b_on;
		logic out_a;
		logic out_b;
		logic ast_a_p;
		logic ast_b_p;
		logic st1_p;
		logic st2_p;
		logic ph_p;
		logic blk_a;
		logic blk_b;
		logic pready;
		logic [31:0] prdata;
		logic pslverr;
	} mpeg_state_t;
endpackage

// ---- rtl/mpeg_edge_gen.sv ----
// Edge generator for one high-resolution pulse unit, with an APB register file.
// Assumes one clock pclk, asynchronous active-low presetn, and filter inputs from the same clock.
//
// Chosen here: the APB interface to the registers and the register addresses.

`include "mpeg_defines.svh"

// Operation
// - Phase trigger from register or filter duty
// - Multi mode: two phases, same duty, offset
// - Multi: A rises ev1, falls ev1+duty+adjA
// - Multi: B rises ev3, falls ev3+duty+adjB
// - Trailing modes: adaptive triggers from duty, offset
// - Multi mode ignores events 2 and 4
// - Multi: B may wrap, A never crosses
// - Resonant: A at ev1, width duty-avg deadtime
// - Resonant: B rise and fall formulas
// - Resonant relies on filter period twice duty
// - Triangle: only B, no A, no adaptive
// - Triangle: B centered, adjusted by adjA/adjB
// - Leading: A falls ev1, rises ev1-duty+adjA
// - Leading: B rises ev4, falls before A
// - Leading: adaptive triggers before event 1
// - Sample and blanking edges use own registers
// - Counter counts zero to limit then restarts
module mpeg_edge_gen (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [15:0] filter_duty,
	input wire logic [15:0] filter_period,
	output logic pulse_output_a,
	output logic pulse_output_b,
	output logic adapt_trig_a,
	output logic adapt_trig_b,
	output logic sample_trig_1,
	output logic sample_trig_2,
	output logic blank_a,
	output logic blank_b,
	output logic phase_trig
);
	mpeg_pkg::mpeg_state_t s;
	mpeg_pkg::mpeg_state_t next_s;

	// -------------------------------------------------------------
	// Next state
	// -------------------------------------------------------------
	always_comb begin
		logic wr;
		logic rd;
		logic wrap;
		logic [15:0] d;
		logic [15:0] avg_dt;
		logic [15:0] a_r;
		logic [15:0] a_f;
		logic [15:0] b_f;
		logic [15:0] b_w;
		logic [15:0] hp;
		logic [15:0] hd;
		logic [31:0] rv;
		logic hit;
		wr = 1'b0;
		rd = 1'b0;
		wrap = 1'b0;
		d = 16'h0000;
		avg_dt = 16'h0000;
		a_r = 16'h0000;
		a_f = 16'h0000;
		b_f = 16'h0000;
		b_w = 16'h0000;
		hp = 16'h0000;
		hd = 16'h0000;
		rv = 32'h0000_0000;
		hit = 1'b1;
		next_s = s;

		// -------------------------------------------------------------
		// Register access
		// -------------------------------------------------------------
		wr = psel && penable && pwrite && s.pready;
		rd = psel && penable && !s.pready;
		next_s.pready = rd;
		if (wr) begin
			case (paddr)
				`MPEG_ADDR_CTRL: begin
					next_s.en = pwdata[`MPEG_CTRL_EN_BIT];
					next_s.mode = pwdata[`MPEG_CTRL_MODE_LSB +: 3];
					next_s.phsrc = pwdata[`MPEG_CTRL_PHSRC_BIT];
				end
				`MPEG_ADDR_PERIOD: next_s.period = pwdata[15:0];
				`MPEG_ADDR_EV1: next_s.ev1 = pwdata[15:0];
				`MPEG_ADDR_EV2: next_s.ev2 = pwdata[15:0];
				`MPEG_ADDR_EV3: next_s.ev3 = pwdata[15:0];
				`MPEG_ADDR_EV4: next_s.ev4 = pwdata[15:0];
				`MPEG_ADDR_CADJ_A: next_s.cadj_a = pwdata[15:0];
				`MPEG_ADDR_CADJ_B: next_s.cadj_b = pwdata[15:0];
				`MPEG_ADDR_ADAPT: next_s.adapt = pwdata[15:0];
				`MPEG_ADDR_PHASE: next_s.phase = pwdata[15:0];
				`MPEG_ADDR_STRIG1: next_s.st1 = pwdata[15:0];
				`MPEG_ADDR_STRIG2: next_s.st2 = pwdata[15:0];
				`MPEG_ADDR_BLKA_BEG: next_s.ba_b = pwdata[15:0];
				`MPEG_ADDR_BLKA_END: next_s.ba_e = pwdata[15:0];
				`MPEG_ADDR_BLKB_BEG: next_s.bb_b = pwdata[15:0];
				`MPEG_ADDR_BLKB_END: next_s.bb_e = pwdata[15:0];
				default: wr = 1'b0;
			endcase
		end
		case (paddr)
			`MPEG_ADDR_CTRL: rv = {27'h0, s.phsrc, s.mode, s.en};
			`MPEG_ADDR_PERIOD: rv = {16'h0, s.period};
			`MPEG_ADDR_EV1: rv = {16'h0, s.ev1};
			`MPEG_ADDR_EV2: rv = {16'h0, s.ev2};
			`MPEG_ADDR_EV3: rv = {16'h0, s.ev3};
			`MPEG_ADDR_EV4: rv = {16'h0, s.ev4};
			`MPEG_ADDR_CADJ_A: rv = {16'h0, s.cadj_a};
			`MPEG_ADDR_CADJ_B: rv = {16'h0, s.cadj_b};
			`MPEG_ADDR_ADAPT: rv = {16'h0, s.adapt};
			`MPEG_ADDR_PHASE: rv = {16'h0, s.phase};
			`MPEG_ADDR_STRIG1: rv = {16'h0, s.st1};
			`MPEG_ADDR_STRIG2: rv = {16'h0, s.st2};
			`MPEG_ADDR_BLKA_BEG: rv = {16'h0, s.ba_b};
			`MPEG_ADDR_BLKA_END: rv = {16'h0, s.ba_e};
			`MPEG_ADDR_BLKB_BEG: rv = {16'h0, s.bb_b};
			`MPEG_ADDR_BLKB_END: rv = {16'h0, s.bb_e};
			`MPEG_ADDR_STATUS: rv = {10'h0, s.out_b, s.out_a, 1'b0, s.lmode, s.cnt};
			default: begin
				rv = 32'h0000_0000;
				hit = 1'b0;
			end
		endcase
		next_s.pslverr = rd && !hit;
		if (rd && !pwrite) begin
			next_s.prdata = rv;
		end else begin
			next_s.prdata = 32'h0000_0000;
		end

		// -------------------------------------------------------------
		// Period counter and latched edge set
		// -------------------------------------------------------------
		wrap = s.cnt >= s.period;
		if (wrap || !s.en) begin
			next_s.cnt = 16'h0000;
		end else begin
			next_s.cnt = s.cnt + 16'h0001;
		end
		if (wrap || !s.en) begin
			d = filter_duty;
			hd = {1'b0, filter_duty[15:1]};
			hp = {1'b0, s.period[15:1]};
			avg_dt = 16'((17'(s.ev3 - s.ev2) + 17'(s.ev1 + s.period - s.ev4)) >> 1);
			next_s.lmode = s.mode;
			if (s.phsrc) begin
				next_s.ph_pos = d;
			end else begin
				next_s.ph_pos = s.phase;
			end
			next_s.ast_a = s.ev1 + d + s.adapt;
			next_s.ast_b = s.ev1 + hd + s.adapt;
			case (mpeg_pkg::mpeg_mode_t'(s.mode))
				mpeg_pkg::MPEG_MULTI: begin
					// Events 2 and 4 take no part here.
					next_s.a_rise = s.ev1;
					a_f = s.ev1 + d + s.cadj_a;
					next_s.a_fall = (a_f > s.period) ? s.period : a_f;
					next_s.b_rise = s.ev3;
					b_w = d + s.cadj_b;
					b_f = s.ev3 + b_w;
					if (b_w > s.period) begin
						next_s.b_fall = 16'hffff;
					end else if (b_f > s.period) begin
						next_s.b_fall = b_f - s.period - 16'h0001;
					end else begin
						next_s.b_fall = b_f;
					end
				end
				mpeg_pkg::MPEG_RESONANT: begin
					// Filter period is assumed to be twice the duty.
					a_f = s.ev1 + d - avg_dt;
					next_s.a_rise = s.ev1;
					next_s.a_fall = a_f;
					next_s.b_rise = a_f + (s.ev3 - s.ev2);
					next_s.b_fall = filter_period - (s.period - s.ev4);
				end
				mpeg_pkg::MPEG_TRIANGLE: begin
					next_s.a_rise = 16'hffff;
					next_s.a_fall = 16'hffff;
					next_s.ast_a = 16'hffff;
					next_s.ast_b = 16'hffff;
					next_s.b_rise = hp - hd + s.cadj_a;
					next_s.b_fall = hp + hd + s.cadj_b;
				end
				mpeg_pkg::MPEG_LEADING: begin
					a_r = s.ev1 - d + s.cadj_a;
					next_s.a_rise = a_r;
					next_s.a_fall = s.ev1;
					next_s.b_rise = s.ev4;
					next_s.b_fall = a_r - (s.ev2 - s.ev3);
					next_s.ast_a = s.ev1 - d + s.adapt;
					next_s.ast_b = s.ev1 - hd + s.adapt;
				end
				default: begin
					a_f = s.ev1 + d + s.cadj_a;
					next_s.a_rise = s.ev1;
					next_s.a_fall = a_f;
					next_s.b_rise = a_f + (s.ev3 - s.ev2);
					next_s.b_fall = s.ev4;
				end
			endcase
		end

		// -------------------------------------------------------------
		// Output edges
		// -------------------------------------------------------------
		next_s.a_on = s.a_on;
		next_s.b_on = s.b_on;
		if (!s.en) begin
			next_s.a_on = 1'b0;
			next_s.b_on = 1'b0;
		end else begin
			if (wrap && s.lmode == 3'(mpeg_pkg::MPEG_MULTI)) begin
				next_s.a_on = 1'b0;
			end
			if (s.cnt == s.a_rise) begin
				next_s.a_on = 1'b1;
			end
			if (s.cnt == s.a_fall) begin
				next_s.a_on = 1'b0;
			end
			if (s.cnt == s.b_rise) begin
				next_s.b_on = 1'b1;
			end
			if (s.cnt == s.b_fall) begin
				next_s.b_on = 1'b0;
			end
		end
		next_s.out_a = next_s.a_on;
		next_s.out_b = next_s.b_on;

		// -------------------------------------------------------------
		// Triggers and blanking
		// -------------------------------------------------------------
		next_s.ast_a_p = s.en && s.cnt == s.ast_a;
		next_s.ast_b_p = s.en && s.cnt == s.ast_b;
		next_s.ph_p = s.en && s.cnt == s.ph_pos;
		next_s.st1_p = s.en && s.cnt == s.st1;
		next_s.st2_p = s.en && s.cnt == s.st2;
		if (!s.en) begin
			next_s.blk_a = 1'b0;
			next_s.blk_b = 1'b0;
		end else begin
			if (s.cnt == s.ba_b) begin
				next_s.blk_a = 1'b1;
			end else if (s.cnt == s.ba_e) begin
				next_s.blk_a = 1'b0;
			end
			if (s.cnt == s.bb_b) begin
				next_s.blk_b = 1'b1;
			end else if (s.cnt == s.bb_e) begin
				next_s.blk_b = 1'b0;
			end
		end
	end

	// -------------------------------------------------------------
	// State register
	// -------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s <= '0;
			s.period <= `MPEG_RST_PERIOD;
			s.a_rise <= 16'hffff;
			s.a_fall <= 16'hffff;
			s.b_rise <= 16'hffff;
			s.b_fall <= 16'hffff;
			s.ast_a <= 16'hffff;
			s.ast_b <= 16'hffff;
			s.ph_pos <= 16'hffff;
		end else begin
			s <= next_s;
		end
	end

	// -------------------------------------------------------------
	// Outputs
	// -------------------------------------------------------------
	assign prdata = s.prdata;
	assign pready = s.pready;
	assign pslverr = s.pslverr;
	assign pulse_output_a = s.out_a;
	assign pulse_output_b = s.out_b;
	assign adapt_trig_a = s.ast_a_p;
	assign adapt_trig_b = s.ast_b_p;
	assign sample_trig_1 = s.st1_p;
	assign sample_trig_2 = s.st2_p;
	assign blank_a = s.blk_a;
	assign blank_b = s.blk_b;
	assign phase_trig = s.ph_p;
endmodule

// ---- tb/mpeg_edge_gen_assertions.sv ----
// Checker for the pulse edge generator ports.
// Assumes it is bound to the design top module.
module mpeg_edge_gen_assertions (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic pulse_output_a,
	input wire logic pulse_output_b,
	input wire logic adapt_trig_a,
	input wire logic adapt_trig_b,
	input wire logic sample_trig_1,
	input wire logic sample_trig_2,
	input wire logic phase_trig
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	ready_pulse_a: assert property (pready |=> !pready) else $error("pready longer than one cycle");
	ready_cause_a: assert property (pready |-> $past(psel && penable)) else $error("pready without access");
	err_ready_a: assert property (pslverr |-> pready) else $error("pslverr without pready");
	rdata_idle_a: assert property (!pready |-> prdata == 32'h0) else $error("prdata not zero");
	adapt_a_pulse_a: assert property (adapt_trig_a |=> !adapt_trig_a) else $error("adaptive a held");
	adapt_b_pulse_a: assert property (adapt_trig_b |=> !adapt_trig_b) else $error("adaptive b held");
	strig_one_a: assert property (sample_trig_1 |=> !sample_trig_1) else $error("sample 1 held");
	strig_two_a: assert property (sample_trig_2 |=> !sample_trig_2) else $error("sample 2 held");
	phase_pulse_a: assert property (phase_trig |=> !phase_trig) else $error("phase trigger held");
	cover property ($rose(pulse_output_a));
	cover property ($rose(pulse_output_b));
	cover property (phase_trig);
endmodule

// ---- tb/mpeg_filter_model.sv ----
// Model of the compensator filter that supplies duty and period.
// Assumes the bench sets the duty on the pclk domain.
module mpeg_filter_model (
	input wire logic pclk,
	input wire logic [15:0] duty_set,
	output logic [15:0] filter_duty,
	output logic [15:0] filter_period
);
	timeunit 1ns;
	timeprecision 1ns;
	always_ff @(posedge pclk) begin
		filter_duty <= duty_set;
		filter_period <= {duty_set[14:0], 1'h0};
	end
endmodule

// ---- tb/mpeg_edge_gen_bench.sv ----
// Bench for the pulse edge generator: APB master, filter model and a table of mode cases.
// Assumes the design, the checker and the filter model are compiled first.
module mpeg_edge_gen_bench;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct {int m, e1, e2, e3, e4, ca, cb, d, wa, wb, off, at, ab;} mpeg_row_t;
	logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, err;
	logic [11:0] paddr = 12'h0;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, pulse_output_a, pulse_output_b, adapt_trig_a, adapt_trig_b;
	logic sample_trig_1, sample_trig_2, blank_a, blank_b, phase_trig;
	logic [15:0] duty_set = 16'h0, filter_duty, filter_period;
	logic [11:0] o, op;
	int miscompares = 0, checks_done = 0, w, n;
	int v[8];
	mpeg_row_t r;
	mpeg_row_t rows[6] = '{
		'{0, 10, 40, 45, 90, 2, 0, 20, 22, 53, 27, 24, 14},
		'{1, 10, 77, 50, 3, 3, 5, 20, 23, 25, 40, 24, 14},
		'{1, 10, 77, 90, 3, 3, 5, 20, 23, 25, 80, 24, 14},
		'{2, 5, 50, 55, 95, 0, 0, 40, 33, 33, 38, 44, 24},
		'{4, 80, 10, 6, 5, 2, 0, 30, 28, 43, 53, 2, 17},
		'{3, 10, 0, 0, 0, 2, 4, 30, -1, 32, -1, -1, -1}
	};
	mpeg_edge_gen dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.filter_duty, .filter_period, .pulse_output_a, .pulse_output_b, .adapt_trig_a, .adapt_trig_b,
		.sample_trig_1, .sample_trig_2, .blank_a, .blank_b, .phase_trig);
	mpeg_filter_model filt (.pclk, .duty_set, .filter_duty, .filter_period);
	assign o = {~blank_a, blank_b, blank_a, sample_trig_2, adapt_trig_b, ~pulse_output_b, ~pulse_output_a,
		phase_trig, sample_trig_1, adapt_trig_a, pulse_output_b, pulse_output_a};
	always #25 pclk = ~pclk;
	always @(posedge pclk) op <= o;
	task automatic finish_test();
		$display("Checks %0d, mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	task automatic chk(input logic ok, input string s);
		checks_done++;
		if (ok !== 1'h1) begin
			$display("ERROR %0t: %s", $time, s);
			miscompares++;
		end
	endtask
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int t;
		t = 0;
		psel <= 1'h1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		do begin
			@(posedge pclk);
			t++;
		end while (pready !== 1'h1 && t < 20);
		rd = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		if (t >= 20) begin
			chk(1'h0, "bus timeout");
			finish_test();
		end
		@(posedge pclk);
	endtask
	task automatic gap(input int a, input int b, output int c);
		int t;
		t = 0;
		c = 0;
		while (!(o[a] & ~op[a]) && t < 400) begin
			@(posedge pclk);
			t++;
		end
		do begin
			@(posedge pclk);
			c++;
		end while (!(o[b] & ~op[b]) && c < 400);
		if (t >= 400 || c >= 400) begin
			chk(1'h0, "edge timeout");
			finish_test();
		end
	endtask
	initial begin
		repeat (5) @(posedge pclk);
		chk({o[10:7], o[4:0]} === 9'h0, "outputs in reset");
		presetn <= 1'h1;
		@(posedge pclk);
		apb(1'h0, 12'h004, 32'h0);
		chk(rd === 32'h0000_03e7, "period reset");
		apb(1'h0, 12'h100, 32'h0);
		chk(err === 1'h1 && rd === 32'h0, "unmapped read");
		foreach (rows[k]) begin
			r = rows[k];
			v = '{99, r.e1, r.e2, r.e3, r.e4, r.ca, r.cb, 4};
			for (int i = 0; i < 8; i++) apb(1'h1, 12'(4 + 4 * i), 32'(v[i]));
			duty_set <= 16'(r.d);
			apb(1'h1, 12'h000, 32'(r.m * 2 + 1));
			repeat (250) @(posedge pclk);
			gap(1, 6, w);
			chk(w == r.wb, "width b");
			if (r.wa < 0) begin
				n = 0;
				repeat (250) begin
					@(posedge pclk);
					if (o[0] !== 1'h0 || o[2] !== 1'h0 || o[7] !== 1'h0) n++;
				end
				chk(n == 0, "a active");
			end else begin
				gap(0, 5, w);
				chk(w == r.wa, "width a");
				gap(0, 1, w);
				chk(w == r.off, "offset b");
				gap(0, 2, w);
				chk(w == r.at, "adaptive a");
				gap(0, 7, w);
				chk(w == r.ab, "adaptive b");
			end
		end
		apb(1'h1, 12'h024, 32'd60);
		apb(1'h1, 12'h028, 32'd70);
		apb(1'h1, 12'h02c, 32'd80);
		apb(1'h1, 12'h030, 32'd20);
		apb(1'h1, 12'h034, 32'd45);
		apb(1'h1, 12'h038, 32'd50);
		apb(1'h1, 12'h000, 32'h3);
		repeat (250) @(posedge pclk);
		gap(0, 4, w);
		chk(w == 50, "phase register");
		gap(0, 3, w);
		chk(w == 60, "sample trigger");
		gap(0, 8, w);
		chk(w == 70, "sample trigger 2");
		gap(0, 9, w);
		chk(w == 10, "blank a begin");
		gap(9, 11, w);
		chk(w == 25, "blank a width");
		gap(0, 10, w);
		chk(w == 40, "blank b begin");
		gap(0, 0, w);
		chk(w == 100, "period");
		apb(1'h1, 12'h000, 32'h13);
		repeat (250) @(posedge pclk);
		gap(0, 4, w);
		chk(w == 20, "phase from duty");
		duty_set <= 16'd50;
		gap(5, 0, w);
		chk(w == 68, "duty latched");
		presetn <= 1'h0;
		repeat (2) @(posedge pclk);
		chk({o[10:7], o[4:0]} === 9'h0, "outputs in second reset");
		presetn <= 1'h1;
		@(posedge pclk);
		apb(1'h0, 12'h000, 32'h0);
		chk(rd === 32'h0, "control after reset");
		finish_test();
	end
endmodule
bind mpeg_edge_gen mpeg_edge_gen_assertions chk_i (.pclk, .presetn, .psel, .penable, .prdata, .pready, .pslverr,
	.pulse_output_a, .pulse_output_b, .adapt_trig_a, .adapt_trig_b, .sample_trig_1, .sample_trig_2, .phase_trig);
